// *** src/hstc_regs.vh ***
// Register map and constants of the high-speed timer/counter core.
// Included by the core module; definitions only.
`ifndef HSTC_REGS_VH
`define HSTC_REGS_VH
// Register offsets on the plain register port
`define HSTC_ADDR_COUNT 4'h0
`define HSTC_ADDR_HIGHBUF 4'h1
`define HSTC_ADDR_CMPA 4'h2
`define HSTC_ADDR_CMPB 4'h3
`define HSTC_ADDR_TOP 4'h4
`define HSTC_ADDR_CMPD 4'h5
`define HSTC_ADDR_CTRLA 4'h6
`define HSTC_ADDR_CTRLB 4'h7
`define HSTC_ADDR_CTRLC 4'h8
`define HSTC_ADDR_CTRLD 4'h9
`define HSTC_ADDR_CTRLE 4'ha
`define HSTC_ADDR_IRQFLAG 4'hb
`define HSTC_ADDR_IRQMASK 4'hc
// Field positions
`define HSTC_CTRLA_WAVE_BIT 0
`define HSTC_CTRLA_PWMA_BIT 1
`define HSTC_CTRLA_PWMB_BIT 2
`define HSTC_CTRLC_PWMD_BIT 0
`define HSTC_CTRLD_FPIE_BIT 7
`define HSTC_CTRLD_FPF_BIT 6
`define HSTC_CTRLE_ENH_BIT 6
`define HSTC_CTRLE_PLLTM_LSB 4
`define HSTC_FLAG_OVF_BIT 2
`define HSTC_FLAG_A_BIT 6
`define HSTC_FLAG_B_BIT 5
`define HSTC_FLAG_D_BIT 7
// Reset values and limits
`define HSTC_TOP_RESET 10'h0ff
`define HSTC_MAX_VALUE 10'h3ff
`define HSTC_BOTTOM_VALUE 10'h000
`define HSTC_CTRL_RESET 8'h00
`endif

// *** src/hstc_core.v ***
// High-speed 10-bit timer/counter core: counter, high-bits buffer,
// compares, flags and masks, clock select with synchronised fast tick.
// Assumes the fast tick pin is asynchronous to core_clk and much slower.
`timescale 1ns/1ns
`default_nettype none
`include "hstc_regs.vh"
module hstc_core #(
    parameter PRE_W = 14
) (
    input wire core_clk, // System clock, 125 MHz
    input wire nrst, // Synchronous reset, active low
    input wire [3:0] regAddr, // Register address
    input wire [7:0] regWrData, // Write data
    input wire regWrStb, // Write strobe
    input wire regRdStb, // Read strobe
    output reg [7:0] regRdData, // Read data, cycle after strobe
    input wire fastPeripheralClock, // Fast tick source pin
    input wire irqAckOvf, // Overflow vector executed
    input wire irqAckA, // Match A vector executed
    input wire irqAckB, // Match B vector executed
    input wire irqAckD, // Match D vector executed
    input wire faultEvent, // Fault protection event
    output wire irqReq, // Any masked flag pending
    output reg [9:0] countValue, // Counter state
    output wire topHit, // Counter equals top
    output wire bottomHit, // Counter at zero
    output reg matchA, // Match A strobe
    output reg matchB, // Match B strobe
    output reg matchD, // Match D strobe
    output reg timerTick // Timer tick pulse
);
    // Register file: shared buffer, wide values and controls
    reg [1:0] sharedHighBitsBuffer;
    reg [10:0] compareValueA;
    reg [10:0] compareValueB;
    reg [9:0] topLimitValue;
    reg [10:0] compareValueD;
    reg [7:0] controlRegA, controlRegB, controlRegC, controlRegD;
    reg [7:0] controlRegE;

    reg overflowFlag, matchFlagA, matchFlagB, matchFlagD;
    reg faultProtectFlag;
    reg [7:0] irqMaskReg;

    reg [9:0] cntShadow_r; // Delayed copy for reads
    reg [1:0] bufShadow_r;
    reg [3:0] flagShadow_r;

    reg [10:0] cmpASync_r, cmpBSync_r, cmpDSync_r;
    reg [9:0] topSync_r;
    reg [7:0] ctrlASync_r, ctrlBSync_r, ctrlCSync_r, ctrlESync_r;

    reg fastMeta_r, fastSync_r, fastLast_r;

    reg [PRE_W-1:0] prescale_r;

    reg cntWrite_r; // Write seen, apply next cycle
    reg [9:0] cntWriteVal_r;
    reg blockMatch_r;

    reg dirDown_r;
    reg extra_r; // Enhanced-mode extra buffer bit

    wire [3:0] clkSel = ctrlBSync_r[3:0];
    wire [1:0] pllTm = ctrlESync_r[`HSTC_CTRLE_PLLTM_LSB +: 2];
    wire enhanced = ctrlESync_r[`HSTC_CTRLE_ENH_BIT];
    wire waveMode = ctrlASync_r[`HSTC_CTRLA_WAVE_BIT];
    wire pwmAny = ctrlASync_r[`HSTC_CTRLA_PWMA_BIT]
        | ctrlASync_r[`HSTC_CTRLA_PWMB_BIT]
        | ctrlCSync_r[`HSTC_CTRLC_PWMD_BIT];

    wire wr = regWrStb;
    reg [9:0] countNext;
    reg tickNow;
    reg ovfEvent;

    // Decode of a low-byte access to a wide register
    function isWide;
        input [3:0] a;
        begin
            isWide = (a == `HSTC_ADDR_COUNT) || (a == `HSTC_ADDR_CMPA)
                || (a == `HSTC_ADDR_CMPB) || (a == `HSTC_ADDR_TOP)
                || (a == `HSTC_ADDR_CMPD);
        end
    endfunction

    // Comparison at the active resolution; enhanced adds a bit
    function cmpHit;
        input [9:0] c;
        input [10:0] v;
        input enh;
        begin
            cmpHit = enh ? ({c, 1'b0} == v) : (c == v[9:0]);
        end
    endfunction

    assign bottomHit = (countValue == `HSTC_BOTTOM_VALUE);
    assign topHit = (countValue == topSync_r);
    assign irqReq = |(flagShadow_r & {irqMaskReg[`HSTC_FLAG_D_BIT],
        irqMaskReg[`HSTC_FLAG_A_BIT], irqMaskReg[`HSTC_FLAG_B_BIT],
        irqMaskReg[`HSTC_FLAG_OVF_BIT]})
        | (faultProtectFlag & controlRegD[`HSTC_CTRLD_FPIE_BIT]);

    // Pin synchroniser for the fast clock; the edge is read from the second and third stages
    always @(posedge core_clk) begin
        if (!nrst) begin
            fastMeta_r <= 1'b0;
            fastSync_r <= 1'b0;
            fastLast_r <= 1'b0;
        end else begin
            fastMeta_r <= fastPeripheralClock;
            fastSync_r <= fastMeta_r;
            fastLast_r <= fastSync_r;
        end
    end

    // Tick source: system prescaler taps, or fast edges once enabled
    always @* begin
        tickNow = 1'b0;

        if (pllTm != 2'h0) begin
            tickNow = (clkSel != 4'h0) & fastSync_r & ~fastLast_r;
        end else begin
            case (clkSel)
                4'h0: tickNow = 1'b0;
                4'h1: tickNow = 1'b1;
                // Period of 2^(n-1) cycles: low n-1 bits all ones
                default: tickNow = &(prescale_r | ~(({{(PRE_W-1){1'b0}},
                    1'b1} << (clkSel - 4'h1)) - 1'b1));
            endcase
        end
    end

    // Counter step per mode: up to top then clear, or up/down in pwm
    always @* begin
        countNext = countValue;
        ovfEvent = 1'b0;

        if (topHit && !(pwmAny && waveMode)) begin
            countNext = `HSTC_BOTTOM_VALUE;
            ovfEvent = 1'b1;
        end else if (pwmAny && waveMode) begin
            // Turn at top in this tick so the peak is top itself
            if (dirDown_r || topHit) begin
                countNext = countValue - 10'h001;
                ovfEvent = (countValue == 10'h001);
            end else begin
                countNext = countValue + 10'h001;
            end
        end else begin
            countNext = countValue + 10'h001;
        end
    end

    // Synchronisation stages between register file and count path
    // One stage per field: costs a cycle, keeps a write whole
    always @(posedge core_clk) begin
        if (!nrst) begin
            cmpASync_r <= 11'h000;
            cmpBSync_r <= 11'h000;
            cmpDSync_r <= 11'h000;
            topSync_r <= `HSTC_TOP_RESET;
            ctrlASync_r <= `HSTC_CTRL_RESET;
            ctrlBSync_r <= `HSTC_CTRL_RESET;
            ctrlCSync_r <= `HSTC_CTRL_RESET;
            ctrlESync_r <= `HSTC_CTRL_RESET;
            prescale_r <= {PRE_W{1'b0}};
        end else begin
            cmpASync_r <= compareValueA;
            cmpBSync_r <= compareValueB;
            cmpDSync_r <= compareValueD;
            topSync_r <= topLimitValue;
            ctrlASync_r <= controlRegA;
            ctrlBSync_r <= controlRegB;
            ctrlCSync_r <= controlRegC;
            ctrlESync_r <= controlRegE;
            prescale_r <= (clkSel == 4'h0) ? {PRE_W{1'b0}}
                : prescale_r + {{(PRE_W-1){1'b0}}, 1'b1};
        end
    end

    // Counter, direction, match strobes and block window
    always @(posedge core_clk) begin
        if (!nrst) begin
            countValue <= `HSTC_BOTTOM_VALUE;
            dirDown_r <= 1'b0;
            cntWrite_r <= 1'b0;
            cntWriteVal_r <= 10'h000;
            blockMatch_r <= 1'b0;
            matchA <= 1'b0;
            matchB <= 1'b0;
            matchD <= 1'b0;
            timerTick <= 1'b0;
        end else begin
            timerTick <= tickNow;
            cntWrite_r <= wr && regAddr == `HSTC_ADDR_COUNT;
            cntWriteVal_r <= {sharedHighBitsBuffer, regWrData};
            matchA <= 1'b0;
            matchB <= 1'b0;
            matchD <= 1'b0;
            // Pending write wins; a tick falling with it is dropped
            if (cntWrite_r) begin
                countValue <= cntWriteVal_r;
                blockMatch_r <= 1'b1;
            end else if (tickNow) begin
                blockMatch_r <= 1'b0;
                if (!blockMatch_r) begin
                    matchA <= cmpHit(countValue, cmpASync_r, enhanced);
                    matchB <= cmpHit(countValue, cmpBSync_r, enhanced);
                    matchD <= cmpHit(countValue, cmpDSync_r, enhanced);
                end
                countValue <= countNext;
                // Direction turns only in up/down mode
                if (pwmAny && waveMode) begin
                    if (topHit)
                        dirDown_r <= 1'b1;
                    else if (countValue == 10'h001 && dirDown_r)
                        dirDown_r <= 1'b0;
                end
            end
        end
    end

    // Register file, shared buffer and flags
    always @(posedge core_clk) begin
        if (!nrst) begin
            sharedHighBitsBuffer <= 2'h0;
            extra_r <= 1'b0;
            compareValueA <= 11'h000;
            compareValueB <= 11'h000;
            compareValueD <= 11'h000;
            topLimitValue <= `HSTC_TOP_RESET;
            controlRegA <= `HSTC_CTRL_RESET;
            controlRegB <= `HSTC_CTRL_RESET;
            controlRegC <= `HSTC_CTRL_RESET;
            controlRegD <= `HSTC_CTRL_RESET;
            controlRegE <= `HSTC_CTRL_RESET;
            irqMaskReg <= 8'h00;
            overflowFlag <= 1'b0;
            matchFlagA <= 1'b0;
            matchFlagB <= 1'b0;
            matchFlagD <= 1'b0;
            faultProtectFlag <= 1'b0;
        end else begin
            // Writes; low byte of a wide register merges the buffer
            if (wr) begin
                case (regAddr)
                    `HSTC_ADDR_HIGHBUF: begin
                        sharedHighBitsBuffer <= regWrData[1:0];
                        extra_r <= regWrData[2];
                    end
                    `HSTC_ADDR_CMPA: compareValueA <=
                        {extra_r, sharedHighBitsBuffer, regWrData};
                    `HSTC_ADDR_CMPB: compareValueB <=
                        {extra_r, sharedHighBitsBuffer, regWrData};
                    `HSTC_ADDR_TOP: topLimitValue <=
                        {sharedHighBitsBuffer, regWrData};
                    `HSTC_ADDR_CMPD: compareValueD <=
                        {extra_r, sharedHighBitsBuffer, regWrData};
                    `HSTC_ADDR_CTRLA: controlRegA <= regWrData;
                    `HSTC_ADDR_CTRLB: controlRegB <= regWrData;
                    `HSTC_ADDR_CTRLC: controlRegC <= regWrData;
                    `HSTC_ADDR_CTRLD: controlRegD <= regWrData;
                    `HSTC_ADDR_CTRLE: controlRegE <= regWrData;
                    `HSTC_ADDR_IRQMASK: irqMaskReg <= regWrData;
                    default: ;
                endcase
            end

            // Low-byte reads load the buffer with the upper bits
            if (regRdStb && isWide(regAddr)) begin
                case (regAddr)
                    `HSTC_ADDR_COUNT:
                        sharedHighBitsBuffer <= cntShadow_r[9:8];
                    `HSTC_ADDR_CMPA:
                        sharedHighBitsBuffer <= compareValueA[9:8];
                    `HSTC_ADDR_CMPB:
                        sharedHighBitsBuffer <= compareValueB[9:8];
                    `HSTC_ADDR_TOP:
                        sharedHighBitsBuffer <= topLimitValue[9:8];
                    default:
                        sharedHighBitsBuffer <= compareValueD[9:8];
                endcase
            end

            // Set beats clear so an event in a clear cycle is kept
            overflowFlag <= (tickNow && !cntWrite_r && ovfEvent)
                | (overflowFlag & ~irqAckOvf & ~(wr && regAddr ==
                `HSTC_ADDR_IRQFLAG && regWrData[`HSTC_FLAG_OVF_BIT]));
            matchFlagA <= matchA | (matchFlagA & ~irqAckA & ~(wr &&
                regAddr == `HSTC_ADDR_IRQFLAG &&
                regWrData[`HSTC_FLAG_A_BIT]));
            matchFlagB <= matchB | (matchFlagB & ~irqAckB & ~(wr &&
                regAddr == `HSTC_ADDR_IRQFLAG &&
                regWrData[`HSTC_FLAG_B_BIT]));
            matchFlagD <= matchD | (matchFlagD & ~irqAckD & ~(wr &&
                regAddr == `HSTC_ADDR_IRQFLAG &&
                regWrData[`HSTC_FLAG_D_BIT]));
            faultProtectFlag <= faultEvent | (faultProtectFlag & ~(wr &&
                regAddr == `HSTC_ADDR_CTRLD &&
                regWrData[`HSTC_CTRLD_FPF_BIT]));
        end
    end

    // Output-side stage: counter, buffer and flags read one cycle late
    always @(posedge core_clk) begin
        if (!nrst) begin
            cntShadow_r <= 10'h000;
            bufShadow_r <= 2'h0;
            flagShadow_r <= 4'h0;
        end else begin
            cntShadow_r <= countValue;
            bufShadow_r <= sharedHighBitsBuffer;
            flagShadow_r <= {matchFlagD, matchFlagA, matchFlagB,
                overflowFlag};
        end
    end

    // Read data, registered; unmapped addresses read zero
    always @(posedge core_clk) begin
        if (!nrst) begin
            regRdData <= 8'h00;
        end else if (regRdStb) begin
            case (regAddr)
                `HSTC_ADDR_COUNT: regRdData <= cntShadow_r[7:0];
                `HSTC_ADDR_HIGHBUF: regRdData <= {6'h00, bufShadow_r};
                `HSTC_ADDR_CMPA: regRdData <= compareValueA[7:0];
                `HSTC_ADDR_CMPB: regRdData <= compareValueB[7:0];
                `HSTC_ADDR_TOP: regRdData <= topLimitValue[7:0];
                `HSTC_ADDR_CMPD: regRdData <= compareValueD[7:0];
                `HSTC_ADDR_CTRLA: regRdData <= controlRegA;
                `HSTC_ADDR_CTRLB: regRdData <= controlRegB;
                `HSTC_ADDR_CTRLC: regRdData <= controlRegC;
                `HSTC_ADDR_CTRLD: regRdData <= {controlRegD[7],
                    faultProtectFlag, controlRegD[5:0]};
                `HSTC_ADDR_CTRLE: regRdData <= controlRegE;
                `HSTC_ADDR_IRQFLAG: regRdData <= {flagShadow_r[3],
                    flagShadow_r[2], flagShadow_r[1], 2'h0,
                    flagShadow_r[0], 2'h0};
                `HSTC_ADDR_IRQMASK: regRdData <= irqMaskReg;
                default: regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// *** testbench/hstc_pll_model.sv ***
// Model of the fast clock source feeding the timer's fast tick pin.
// Runs from core_clk; edges come only in runs and only after lock.
`timescale 1ns/1ns
`default_nettype none
module hstc_pll_model #(
    parameter int LOCK_CYC = 40,
    parameter int HALF = 4,
    parameter int EDGES = 8
) (
    input wire logic core_clk, // Model time base
    input wire logic pllEn, // Enable from software
    input wire logic burst, // Request one run of edges
    output logic pllLock, // Lock indication
    output logic fastPeripheralClock // Fast tick output
);
    int lockCnt = 0;
    int phase = 0;
    int left = 0;
    logic clk_r = 1'h0;
    logic lock_r = 1'h0;
    assign pllLock = lock_r;
    assign fastPeripheralClock = clk_r;
    // Lock is withheld until the settling time has run out
    always @(posedge core_clk) begin
        lockCnt <= pllEn ? lockCnt + 1 : 0;
        lock_r <= pllEn && lockCnt >= LOCK_CYC;
    end
    // Output stands low between runs, so no stray ticks leak through
    always @(posedge core_clk) begin
        if (burst && lock_r && left == 0) begin
            left <= 2 * EDGES;
            phase <= 0;
        end else if (left != 0) begin
            phase <= (phase == HALF - 1) ? 0 : phase + 1;
            if (phase == HALF - 1) begin
                clk_r <= !clk_r;
                left <= left - 1;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/hstc_core_asserts.sv ***
// Checker for the timer core; watches only the core's ports.
// Assumes the register offsets of the shared header.
`timescale 1ns/1ns
`default_nettype none
`include "hstc_regs.vh"
module hstc_core_asserts (
    input wire logic core_clk, // System clock
    input wire logic nrst, // Sync reset, active low
    input wire logic [3:0] regAddr, // Register address
    input wire logic [7:0] regWrData, // Write data
    input wire logic regWrStb, // Write strobe
    input wire logic regRdStb, // Read strobe
    input wire logic [7:0] regRdData, // Read data
    input wire logic irqReq, // Masked request
    input wire logic [9:0] countValue, // Counter
    input wire logic bottomHit, // Counter at zero
    input wire logic matchA, // Match A strobe
    input wire logic matchB, // Match B strobe
    input wire logic matchD, // Match D strobe
    input wire logic timerTick // Tick pulse
);
    wire wrCnt = regWrStb && regAddr == `HSTC_ADDR_COUNT;
    wire wrBuf = regWrStb && regAddr == `HSTC_ADDR_HIGHBUF;
    wire anyMatch = matchA || matchB || matchD;
    logic [1:0] hb_r;
    logic [1:0] tk_r;
    logic [2:0] cw_r;
    logic topWr_r, cntWr_r, maskOn_r, csOff_r;
    // Shadow of what software wrote; reads may also load the buffer,
    // so the buffer shadow is trusted only right after its write
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            hb_r <= 2'h0;
            tk_r <= 2'h0;
            cw_r <= 3'h0;
            topWr_r <= 1'h0;
            cntWr_r <= 1'h0;
            maskOn_r <= 1'h0;
            csOff_r <= 1'h1;
        end else begin
            hb_r <= wrBuf ? regWrData[1:0] : hb_r;
            tk_r <= {tk_r[0], timerTick};
            cw_r <= {cw_r[1:0], wrCnt};
            topWr_r <= topWr_r || (regWrStb && regAddr == `HSTC_ADDR_TOP);
            cntWr_r <= cntWr_r || wrCnt;
            maskOn_r <= maskOn_r || (regWrStb && regWrData != 8'h00 &&
                (regAddr == `HSTC_ADDR_IRQMASK ||
                regAddr == `HSTC_ADDR_CTRLD));
            if (regWrStb && regAddr == `HSTC_ADDR_CTRLB) begin
                csOff_r <= regWrData[3:0] == 4'h0;
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence sBufThenCnt;
        wrBuf ##1 wrCnt;
    endsequence
    sequence sNearTick;
        timerTick or ##[0:2] timerTick;
    endsequence
    AST_WR_COUNT: assert property (
        sBufThenCnt |-> ##2 countValue == $past({hb_r, regWrData}, 2))
        else $error("counter write did not land whole");
    AST_BOTTOM: assert property (
        bottomHit == (countValue == `HSTC_BOTTOM_VALUE))
        else $error("bottom flag disagrees with counter");
    AST_TOP_RESET: assert property (
        !topWr_r && !cntWr_r |-> countValue <= `HSTC_TOP_RESET)
        else $error("counter passed the reset top");
    AST_STOP: assert property (
        csOff_r && $past(csOff_r, 3) |-> !timerTick)
        else $error("tick while no clock selected");
    AST_HOLD: assert property (
        $changed(countValue) |-> (|tk_r || |cw_r || wrCnt) or sNearTick)
        else $error("counter moved without tick or write");
    AST_BLOCK: assert property (
        wrCnt |-> ##1 (!anyMatch) [*3])
        else $error("match right after counter write");
    AST_MATCH_PULSE: assert property (
        matchA |=> !matchA)
        else $error("match A longer than one cycle");
    AST_IRQ_QUIET: assert property (
        !maskOn_r |-> !irqReq)
        else $error("request with every mask clear");
    AST_RD_IDLE: assert property (
        !$past(regRdStb) |-> regRdData == 8'h00)
        else $error("read data outside its cycle");
endmodule
bind hstc_core hstc_core_asserts u_chk (
    .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .irqReq(irqReq), .countValue(countValue),
    .bottomHit(bottomHit), .matchA(matchA), .matchB(matchB),
    .matchD(matchD), .timerTick(timerTick)
);
`default_nettype wire

// *** testbench/hstc_tb.sv ***
// Self-checking bench for the timer core with a fast clock model.
// Register port driven as a bus master; the checker is bound in.
`timescale 1ns/1ns
`default_nettype none
`include "hstc_regs.vh"
module tb;
    logic core_clk = 1'h0;
    logic nrst = 1'h0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrStb = 1'h0;
    logic regRdStb = 1'h0;
    logic [3:0] ack = 4'h0;
    logic faultEvent = 1'h0;
    logic pllEn = 1'h0;
    logic burst = 1'h0;
    wire [7:0] regRdData;
    wire [9:0] countValue;
    wire pllLock, fastClk, irqReq, topHit, bottomHit;
    wire matchA, matchB, matchD, timerTick;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    logic [9:0] mx;
    logic sawBot, sawDown;
    hstc_core #(.PRE_W(14)) dut (
        .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .fastPeripheralClock(fastClk),
        .irqAckOvf(ack[0]), .irqAckA(ack[1]), .irqAckB(ack[2]),
        .irqAckD(ack[3]), .faultEvent(faultEvent), .irqReq(irqReq),
        .countValue(countValue), .topHit(topHit), .bottomHit(bottomHit),
        .matchA(matchA), .matchB(matchB), .matchD(matchD),
        .timerTick(timerTick)
    );
    hstc_pll_model #(.LOCK_CYC(40), .HALF(4), .EDGES(8)) u_pll (
        .core_clk(core_clk), .pllEn(pllEn), .burst(burst),
        .pllLock(pllLock), .fastPeripheralClock(fastClk)
    );
    // Clock at 125 MHz
    always #4 core_clk = !core_clk;
    // Hang guard, well above the length of all tests
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk) regWrStb <= 1'h0;
    endtask
    // Write strobe holds one cycle; the next task lowers it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'h1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regWrStb <= 1'h0;
        regAddr <= a;
        regRdStb <= 1'h1;
        @(posedge core_clk);
        regRdStb <= 1'h0;
        #1 d = regRdData;
    endtask
    task automatic chk(input string n, input logic [9:0] e,
        input logic [9:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input string n, input logic [3:0] a,
        input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(n, {2'h0, e}, {2'h0, d});
    endtask
    // Count for n cycles, noting peak, bottom and any step down to a nonzero value
    task automatic run(input int n);
        logic [9:0] last;
        last = countValue;
        mx = 10'h000;
        sawBot = 1'h0;
        sawDown = 1'h0;
        repeat (n) begin
            cyc(1);
            #1;
            mx = (countValue > mx) ? countValue : mx;
            sawBot = sawBot | (bottomHit === 1'h1);
            sawDown = sawDown | (countValue < last && countValue != 0);
            last = countValue;
        end
    endtask
    task automatic t_reset;
        rc("top low", `HSTC_ADDR_TOP, 8'hff);
        rc("high buffer", `HSTC_ADDR_HIGHBUF, 8'h00);
        for (int a = 6; a < 13; a++) rc("ctrl", a[3:0], 8'h00);
        for (int a = 13; a < 16; a++) begin
            wr(a[3:0], 8'hff);
            rc("unmapped", a[3:0], 8'h00);
        end
        $display("test reset done");
    endtask
    task automatic t_readback;
        for (int a = 2; a < 10; a++) begin
            wr(a[3:0], {a[3:0], 4'h2});
            rc("readback", a[3:0], {a[3:0], 4'h2});
        end
        for (int a = 6; a < 10; a++) wr(a[3:0], 8'h00);
        cyc(2);
        $display("test readback done");
    endtask
    task automatic t_wide;
        logic [7:0] d;
        wr(`HSTC_ADDR_HIGHBUF, 8'h02);
        wr(`HSTC_ADDR_COUNT, 8'h34);
        wr(`HSTC_ADDR_HIGHBUF, 8'h01);
        wr(`HSTC_ADDR_CMPA, 8'h77);
        wr(`HSTC_ADDR_HIGHBUF, 8'h00);
        cyc(4);
        chk("count", 10'h234, countValue);
        rd(`HSTC_ADDR_COUNT, d);
        chk("count low", 10'h034, {2'h0, d});
        cyc(4);
        rc("buffer from count", `HSTC_ADDR_HIGHBUF, 8'h02);
        rc("cmp A low", `HSTC_ADDR_CMPA, 8'h77);
        cyc(4);
        rc("buffer from cmp A", `HSTC_ADDR_HIGHBUF, 8'h01);
        wr(`HSTC_ADDR_HIGHBUF, 8'h00);
        wr(`HSTC_ADDR_COUNT, 8'h9c);
        cyc(4);
        chk("narrow count", 10'h09c, countValue);
        $display("test wide access done");
    endtask
    task automatic t_count;
        logic [7:0] d;
        for (int m = 0; m < 2; m++) begin
            wr(`HSTC_ADDR_HIGHBUF, 8'h00);
            wr(`HSTC_ADDR_TOP, 8'h05);
            wr(`HSTC_ADDR_COUNT, 8'h00);
            wr(`HSTC_ADDR_CTRLA, m == 0 ? 8'h00 : 8'h03);
            wr(`HSTC_ADDR_IRQFLAG, 8'hff);
            wr(`HSTC_ADDR_CTRLB, 8'h01);
            run(40);
            chk("peak", 10'h005, mx);
            chk("bottom", 10'h001, {9'h0, sawBot});
            chk("down", {9'h0, m[0]}, {9'h0, sawDown});
            rd(`HSTC_ADDR_IRQFLAG, d);
            chk("ovf", 10'h001, {9'h0, d[`HSTC_FLAG_OVF_BIT]});
            wr(`HSTC_ADDR_CTRLB, 8'h00);
            cyc(4);
            mx = countValue;
            cyc(20);
            chk("stopped", mx, countValue);
            chk("top", {9'h0, mx == 10'h005}, {9'h0, topHit});
        end
        wr(`HSTC_ADDR_CTRLA, 8'h00);
        wr(`HSTC_ADDR_IRQFLAG, 8'hff);
        cyc(4);
        rc("flags cleared", `HSTC_ADDR_IRQFLAG, 8'h00);
        $display("test counting done");
    endtask
    task automatic t_match;
        logic [7:0] d;
        logic seen;
        int k;
        wr(`HSTC_ADDR_CMPA, 8'h03);
        wr(`HSTC_ADDR_IRQMASK, 8'h40);
        wr(`HSTC_ADDR_COUNT, 8'h00);
        wr(`HSTC_ADDR_CTRLB, 8'h01);
        k = 0;
        while (matchA !== 1'h1 && k < 40) begin
            cyc(1);
            #1 k++;
        end
        chk("match A", 10'h001, {9'h0, matchA});
        wr(`HSTC_ADDR_CTRLB, 8'h00);
        cyc(6);
        rd(`HSTC_ADDR_IRQFLAG, d);
        chk("flag A", 10'h001, {9'h0, d[`HSTC_FLAG_A_BIT]});
        chk("irq", 10'h001, {9'h0, irqReq});
        @(posedge core_clk) ack <= 4'hf;
        @(posedge core_clk) ack <= 4'h0;
        cyc(6);
        chk("irq acked", 10'h000, {9'h0, irqReq});
        wr(`HSTC_ADDR_COUNT, 8'h03);
        wr(`HSTC_ADDR_CTRLB, 8'h01);
        seen = 1'h0;
        repeat (5) begin
            cyc(1);
            #1 seen = seen | (matchA === 1'h1);
        end
        chk("blocked match", 10'h000, {9'h0, seen});
        wr(`HSTC_ADDR_CTRLB, 8'h00);
        wr(`HSTC_ADDR_IRQMASK, 8'h00);
        $display("test match done");
    endtask
    task automatic t_fast;
        int k;
        int ticks;
        cyc(1);
        pllEn <= 1'h1;
        k = 0;
        while (pllLock !== 1'h1 && k < 200) begin
            cyc(1);
            k++;
        end
        wr(`HSTC_ADDR_CTRLE, 8'h10);
        wr(`HSTC_ADDR_CTRLB, 8'h01);
        cyc(8);
        @(posedge core_clk) burst <= 1'h1;
        @(posedge core_clk) burst <= 1'h0;
        ticks = 0;
        repeat (100) begin
            cyc(1);
            #1 ticks += (timerTick === 1'h1);
        end
        chk("fast ticks", 10'h008, ticks[9:0]);
        wr(`HSTC_ADDR_CTRLB, 8'h00);
        cyc(1);
        faultEvent <= 1'h1;
        cyc(1);
        faultEvent <= 1'h0;
        cyc(4);
        rc("fault flag", `HSTC_ADDR_CTRLD, 8'h40);
        wr(`HSTC_ADDR_CTRLD, 8'h40);
        rc("fault cleared", `HSTC_ADDR_CTRLD, 8'h00);
        $display("test fast clock done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Main sequence after the reset hold
    initial begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'h1;
        t_reset();
        t_readback();
        t_wide();
        t_count();
        t_match();
        t_fast();
        cyc(4);
        summarize();
    end
endmodule
`default_nettype wire
